// >>> bench/static_zone_bus_cycle_sequencer_test.sv
// Purpose: directed bench for the bus cycle sequencer
// Assumes: zero wait apb, memory model on the pins
// Notes:   pin activity counted per request between launch and response
`timescale 1ns/10ps
`include "szbcs_consts.vh"
module static_zone_bus_cycle_sequencer_test;
  reg         pclk, presetn, psel, penable, pwrite, perr;
  reg         req_valid, req_write, onchip, allin, cnt_en, rs_q;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdv;
  reg  [1:0]  req_zone, req_be;
  reg  [15:0] req_addr, req_wdata, got;
  reg  [2:0]  req_status;
  wire [31:0] prdata;
  wire        pready, pslverr, req_ready, rsp_valid, data_oe, io_select_n, read_strobe_n, cdl;
  wire [15:0] rsp_rdata, mem_addr, data_out, data_in;
  wire [1:0]  zone_select_n, write_strobes_n, byte_lane_enables;
  wire [2:0]  bus_status_lines;
  integer     fails, checks_done, n_wr, n_oe, n_rd, n_sel, n_mon, n_rdf, n_bst, h;
  szbcs_bus_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_zone(req_zone), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
    .req_status(req_status), .req_io_onchip(onchip), .req_io_all_inputs(allin),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .zone_select_n(zone_select_n),
    .io_select_n(io_select_n), .read_strobe_n(read_strobe_n),
    .write_strobes_n(write_strobes_n), .core_direction_line(cdl),
    .byte_lane_enables(byte_lane_enables), .bus_status_lines(bus_status_lines));
  szbcs_mem_model mem (.pclk(pclk), .mem_addr(mem_addr), .data_out(data_out),
    .data_oe(data_oe), .zone_select_n(zone_select_n), .io_select_n(io_select_n),
    .read_strobe_n(read_strobe_n), .data_in(data_in));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (cnt_en) begin
    n_wr = n_wr + (write_strobes_n != 2'b11);
    n_oe = n_oe + data_oe;
    n_rd = n_rd + !read_strobe_n;
    n_sel = n_sel + ((zone_select_n != 2'b11) || !io_select_n);
    n_mon = n_mon + (byte_lane_enables != 2'b00);
    n_rdf = n_rdf + (!read_strobe_n && rs_q);
    n_bst = n_bst + (cdl && bus_status_lines == 3'h5);
    rs_q = read_strobe_n;
  end
  function [31:0] zc(input [2:0] w, input [1:0] hd, input burst_read_enable, burst_wait, bw, fast_read_enable);
    zc = {16'h0, 4'h0, fast_read_enable, 3'b000, bw, burst_wait, burst_read_enable, hd, w};
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i = i + 1; end while (pready !== 1'b1 && i < 20);
    rdv = prdata;
    perr = pslverr;
    psel <= 0; penable <= 0;
    if (i >= 20) begin fails = fails + 1; summarize; end
  endtask
  task rq(input w, input [1:0] z, input [15:0] a, input [1:0] be, input [15:0] d);
    integer i;
    @(posedge pclk);
    n_wr = 0; n_oe = 0; n_rd = 0; n_sel = 0; n_mon = 0; n_rdf = 0; n_bst = 0; rs_q = 1;
    cnt_en <= 1; req_valid <= 1; req_write <= w; req_zone <= z;
    req_addr <= a; req_be <= be; req_wdata <= d;
    i = 0;
    do begin @(posedge pclk); i = i + 1; end while (req_ready !== 1'b1 && i < 100);
    req_valid <= 0;
    i = 0;
    do begin @(posedge pclk); i = i + 1; end while (rsp_valid !== 1'b1 && i < 100);
    got = rsp_rdata;
    cnt_en <= 0;
    if (i >= 100) begin fails = fails + 1; summarize; end
    @(negedge pclk);
  endtask
  task t_reset;
    apb(0, `SZBCS_OFF_BUS_CFG, 0);   chk("bus_cfg", rdv, 32'h07);
    apb(0, `SZBCS_OFF_ZONE0_CFG, 0); chk("zone0_cfg", rdv, 32'h069f);
    apb(0, 8'h14, 0);                chk("unmapped_err", perr, 1);
    // default early write, wait seven, hold three
    rq(1, `SZBCS_ZONE_0, 16'h0010, 2'b11, 16'h4321);
    chk("def_wr", n_wr, 10);
    chk("def_oe", n_oe, 12);
    $display("test reset done");
  endtask
  task t_early;
    apb(1, `SZBCS_OFF_BUS_CFG, 32'h03);
    for (h = 0; h < 4; h = h + 1) begin
      apb(1, `SZBCS_OFF_ZONE0_CFG, zc(0, h, 0, 0, 1, 0));
      rq(1, `SZBCS_ZONE_0, 16'h0040, 2'b11, 16'hbe00 + h);
      chk("ew_wr", n_wr, 3);
      chk("ew_oe", n_oe, 2 + h);
      chk("ew_sel", n_sel, 1);
      chk("ew_data", mem.w_data_r, 16'hbe00 + h);
    end
    $display("test early write done");
  endtask
  task t_late;
    apb(1, `SZBCS_OFF_BUS_CFG, 32'h02);
    apb(1, `SZBCS_OFF_ZONE1_CFG, zc(1, 1, 0, 0, 1, 0));
    rq(1, `SZBCS_ZONE_1, 16'h0080, 2'b11, 16'h1357);
    chk("lw_wr", n_wr, 2);
    chk("lw_oe", n_oe, 3);
    chk("lw_sel", n_sel, 3);
    chk("lw_data", mem.w_data_r, 16'h1357);
    chk("lw_addr", mem.w_addr_r, 16'h0080);
    $display("test late write done");
  endtask
  task t_read;
    apb(1, `SZBCS_OFF_ZONE0_CFG, zc(2, 0, 0, 0, 1, 0));
    rq(0, `SZBCS_ZONE_0, 16'h0124, 2'b11, 0);
    chk("nr_rd", n_rd, 3);
    chk("nr_sel", n_sel, 4);
    chk("nr_data", got, 16'h7f24);
    apb(1, `SZBCS_OFF_ZONE0_CFG, zc(0, 0, 1, 1, 0, 0));
    rq(0, `SZBCS_ZONE_0, 16'h0124, 2'b11, 0);
    chk("br_rdf", n_rdf, 1);
    chk("br_data", got, 16'h2524);
    $display("test normal read done");
  endtask
  task t_fast;
    apb(1, `SZBCS_OFF_ZONE0_CFG, zc(7, 3, 0, 0, 1, 1));
    rq(0, `SZBCS_ZONE_0, 16'h0124, 2'b11, 0);
    chk("fr_rd", n_rd, 1);
    chk("fr_sel", n_sel, 1);
    chk("fr_data", got, 16'h7f24);
    apb(1, `SZBCS_OFF_ZONE0_CFG, zc(7, 3, 1, 0, 0, 1));
    rq(0, `SZBCS_ZONE_0, 16'h0124, 2'b11, 0);
    chk("fs_sel", n_sel, 2);
    chk("fs_data", got, 16'h2524);
    $display("test fast read done");
  endtask
  task t_io;
    apb(1, `SZBCS_OFF_IO_CFG, 32'h0080);
    rq(0, `SZBCS_ZONE_IO, 16'h1233, 2'b11, 0);
    chk("io_data", got, 16'h6933);
    chk("io_rd", n_rd, 1);
    onchip <= 1;
    rq(1, `SZBCS_ZONE_IO, 16'h1234, 2'b11, 16'h55aa);
    chk("onchip_sel", n_sel + n_wr, 0);
    onchip <= 0;
    allin <= 1;
    rq(1, `SZBCS_ZONE_IO, 16'h1234, 2'b11, 16'h55aa);
    chk("inputs_sel", n_sel + n_wr, 0);
    allin <= 0;
    $display("test io done");
  endtask
  task t_mon;
    apb(1, `SZBCS_OFF_BUS_CFG, 32'h03);
    rq(0, `SZBCS_ZONE_INT, 16'h0200, 2'b01, 0);
    chk("mon_on", n_mon, 1);
    chk("mon_sel", n_sel, 0);
    chk("mon_status", n_bst, 1);
    apb(1, `SZBCS_OFF_BUS_CFG, 32'h01);
    rq(0, `SZBCS_ZONE_INT, 16'h0200, 2'b01, 0);
    chk("mon_off", n_mon, 0);
    $display("test monitoring done");
  endtask
  initial begin
    fails = 0; checks_done = 0; cnt_en = 0; rs_q = 1; presetn = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req_valid = 0; req_write = 0; req_zone = 0; req_addr = 0; req_be = 0;
    req_wdata = 0; req_status = 3'h5; onchip = 0; allin = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_early;
    t_late;
    t_read;
    t_fast;
    t_io;
    t_mon;
    summarize;
  end
endmodule

// >>> bench/szbcs_mem_model.sv
// Purpose: static memory and io latch model on the far side
// Assumes: read data answers within the strobe clock
// Notes:   released bus shows the inverted last value
`timescale 1ns/10ps
module szbcs_mem_model (
  // clock
  input  wire        pclk,
  // bus pins
  input  wire [15:0] mem_addr,
  input  wire [15:0] data_out,
  input  wire        data_oe,
  input  wire [1:0]  zone_select_n,
  input  wire        io_select_n,
  input  wire        read_strobe_n,
  output wire [15:0] data_in
);
  reg  [15:0] last_r;
  reg  [15:0] w_addr_r;
  reg  [15:0] w_data_r;
  wire        sel = (zone_select_n != 2'b11) || !io_select_n;
  initial last_r = 16'h00ff;
  // answer mixes high address bits so a cut io address shows
  assign data_in = (sel && !read_strobe_n) ?
                   {mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h5a, mem_addr[7:0]} : ~last_r;
  always @(posedge pclk) begin
    last_r <= data_in;
    if (sel && data_oe) begin
      w_addr_r <= mem_addr;
      w_data_r <= data_out;
    end
  end
endmodule

// >>> bench/szbcs_sva.sv
// Purpose: port checker for the bus cycle sequencer
// Assumes: sees only top module ports, not the configuration
// Notes:   relations that hold whatever the zone settings are
`timescale 1ns/10ps
module szbcs_sva #(
  parameter AW = 16
) (
  // clock and reset
  input wire          pclk,
  input wire          presetn,
  // core side
  input wire          req_valid,
  input wire          req_ready,
  input wire          rsp_valid,
  // memory bus and monitoring pins
  input wire [AW-1:0] mem_addr,
  input wire          data_oe,
  input wire [1:0]    zone_select_n,
  input wire          io_select_n,
  input wire          read_strobe_n,
  input wire [1:0]    write_strobes_n,
  input wire [1:0]    byte_lane_enables
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sel = (zone_select_n != 2'b11) || !io_select_n;
  wire wr  = write_strobes_n != 2'b11;
  sequence s_take; req_valid && req_ready; endsequence
  // longest access here stays under forty clocks
  sequence s_done; ##[1:40] rsp_valid; endsequence
  property p_done; s_take |-> s_done; endproperty
  property p_excl; !(wr && !read_strobe_n); endproperty
  property p_oe_rd; data_oe |-> read_strobe_n; endproperty
  property p_wr_float; (wr && !$past(wr)) |-> !data_oe; endproperty
  property p_addr_hold; (data_oe && $past(data_oe)) |-> $stable(mem_addr); endproperty
  property p_rd_sel; $fell(read_strobe_n) |-> sel; endproperty
  property p_sel_excl; !io_select_n |-> zone_select_n == 2'b11; endproperty
  property p_mon_quiet;
    byte_lane_enables != 2'b00 |-> !sel && !wr && read_strobe_n && !data_oe;
  endproperty
  property p_mon_done; byte_lane_enables != 2'b00 |=> rsp_valid; endproperty
  a_done: assert property (p_done)
    else $error("request did not finish in time");
  a_excl: assert property (p_excl)
    else $error("read and write strobes active together");
  a_oe_rd: assert property (p_oe_rd)
    else $error("data driven while read strobe active");
  a_wr_float: assert property (p_wr_float)
    else $error("data driven in first write clock");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved while write data driven");
  a_rd_sel: assert property (p_rd_sel)
    else $error("read strobe without select");
  a_sel_excl: assert property (p_sel_excl)
    else $error("io select together with zone select");
  a_mon_quiet: assert property (p_mon_quiet)
    else $error("monitoring cycle moved data controls");
  a_mon_done: assert property (p_mon_done)
    else $error("monitoring cycle longer than one clock");
endmodule

bind szbcs_bus_sequencer szbcs_sva #(.AW(AW)) u_sva (
  .pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .mem_addr(mem_addr), .data_oe(data_oe),
  .zone_select_n(zone_select_n), .io_select_n(io_select_n),
  .read_strobe_n(read_strobe_n), .write_strobes_n(write_strobes_n),
  .byte_lane_enables(byte_lane_enables)
);

// >>> hdl/szbcs_bus_sequencer.v
// Purpose: turns core reads and writes into static memory and I/O bus cycles
// Assumes: core request inputs synchronous to pclk; pins registered
// Notes:   one request at a time; word on 8-bit zone becomes burst or two cycles
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "szbcs_consts.vh"

module szbcs_bus_sequencer #(
  parameter AW = 16
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // core request
  input  wire          req_valid,
  output wire          req_ready,
  input  wire          req_write,
  input  wire [1:0]    req_zone,
  input  wire [AW-1:0] req_addr,
  input  wire [1:0]    req_be,
  input  wire [15:0]   req_wdata,
  input  wire [2:0]    req_status,
  input  wire          req_io_onchip,
  input  wire          req_io_all_inputs,
  // core response
  output reg           rsp_valid,
  output reg  [15:0]   rsp_rdata,
  // memory bus pins
  output reg  [AW-1:0] mem_addr,
  output reg  [15:0]   data_out,
  output reg           data_oe,
  input  wire [15:0]   data_in,
  output reg  [1:0]    zone_select_n,
  output reg           io_select_n,
  output reg           read_strobe_n,
  output reg  [1:0]    write_strobes_n,
  // monitoring pins
  output reg           core_direction_line,
  output reg  [1:0]    byte_lane_enables,
  output reg  [2:0]    bus_status_lines
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_GAP  = 4'h1;
  localparam [3:0] S_T1   = 4'h2;
  localparam [3:0] S_TIW  = 4'h3;
  localparam [3:0] S_T2   = 4'h4;
  localparam [3:0] S_TBW  = 4'h5;
  localparam [3:0] S_T2B  = 4'h6;
  localparam [3:0] S_T3   = 4'h7;
  localparam [3:0] S_HOLD = 4'h8;
  localparam [3:0] S_FAST = 4'h9;
  localparam [3:0] S_MON  = 4'ha;

  reg [7:0]    bus_cfg_r;
  reg [15:0]   zone0_cfg_r;
  reg [15:0]   zone1_cfg_r;
  reg [15:0]   io_cfg_r;

  reg [3:0]    st_r,     st_nxt;
  reg [2:0]    cnt_r,    cnt_nxt;
  reg          a_wr_r,   a_wr_nxt;
  reg          a_ew_r,   a_ew_nxt;
  reg [1:0]    a_zone_r, a_zone_nxt;
  reg [AW-1:0] a_addr_r, a_addr_nxt;
  reg [1:0]    a_be_r,   a_be_nxt;
  reg [15:0]   a_wd_r,   a_wd_nxt;
  reg [2:0]    a_st_r,   a_st_nxt;
  reg          a_fast_r, a_fast_nxt;
  reg          a_bst_r,  a_bst_nxt;
  reg          a_spl_r,  a_spl_nxt;
  reg          a_step_r, a_step_nxt;
  reg [15:0]   rd_r,     rd_nxt;
  reg          done;
  reg          term;
  reg          launch;
  reg          gap;

  function [15:0] cfg_of;
    input [1:0]  z;
    input [15:0] c0;
    input [15:0] c1;
    input [15:0] cio;
    begin
      case (z)
        `SZBCS_ZONE_0:  cfg_of = c0;
        `SZBCS_ZONE_1:  cfg_of = c1;
        `SZBCS_ZONE_IO: cfg_of = cio;
        default:        cfg_of = 16'h0000;
      endcase
    end
  endfunction

  function [3:0] start_of;
    input [1:0] z;
    input       fast;
    input       wr;
    begin
      if (z == `SZBCS_ZONE_INT)
        start_of = S_MON;
      else if (fast && !wr)
        start_of = S_FAST;
      else
        start_of = S_T1;
    end
  endfunction

  wire [15:0] cur_cfg  = cfg_of(a_zone_r, zone0_cfg_r, zone1_cfg_r, io_cfg_r);
  wire [15:0] req_cfg  = cfg_of(req_zone, zone0_cfg_r, zone1_cfg_r, io_cfg_r);
  wire [2:0]  wait_c   = cur_cfg[`SZBCS_WAIT_LSB+2:`SZBCS_WAIT_LSB];
  wire [1:0]  hold_c   = cur_cfg[`SZBCS_HOLD_LSB+1:`SZBCS_HOLD_LSB];
  wire        cur_wide = cur_cfg[`SZBCS_BW_BIT];
  wire        cur_hi   = !cur_wide && (a_step_r || a_be_r == 2'b10);
  wire        sec_pend = a_spl_r && !a_step_r;
  wire        req_io   = req_zone == `SZBCS_ZONE_IO;
  wire        req_word = req_be == 2'b11;
  // internal access with no monitoring, or an I/O access the chip serves itself
  wire        req_null = (req_zone == `SZBCS_ZONE_INT && !bus_cfg_r[`SZBCS_OBR_BIT]) ||
                         (req_io && (req_io_onchip ||
                                     (req_write && req_io_all_inputs)));

  wire [15:0] n_cfg    = cfg_of(a_zone_nxt, zone0_cfg_r, zone1_cfg_r, io_cfg_r);

  assign req_ready = term && !sec_pend && (st_r == S_IDLE || !req_null);

  // end of the current access: a new one may be taken this clock
  always @* begin
    case (st_r)
      S_IDLE:  term = 1'b1;
      S_T2:    term = !(!a_wr_r && a_bst_r && !a_step_r) &&
                      !(a_wr_r && a_ew_r) && hold_c == 2'd0;
      S_T2B:   term = hold_c == 2'd0;
      S_T3:    term = hold_c == 2'd0;
      S_HOLD:  term = cnt_r == 3'd0;
      S_FAST:  term = 1'b1;
      S_MON:   term = 1'b1;
      default: term = 1'b0;
    endcase
  end

  always @* begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    a_wr_nxt   = a_wr_r;
    a_ew_nxt   = a_ew_r;
    a_zone_nxt = a_zone_r;
    a_addr_nxt = a_addr_r;
    a_be_nxt   = a_be_r;
    a_wd_nxt   = a_wd_r;
    a_st_nxt   = a_st_r;
    a_fast_nxt = a_fast_r;
    a_bst_nxt  = a_bst_r;
    a_spl_nxt  = a_spl_r;
    a_step_nxt = a_step_r;
    rd_nxt     = rd_r;
    done       = 1'b0;
    launch     = 1'b0;
    gap        = 1'b0;
    case (st_r)
      S_T1: begin
        if (wait_c != 3'd0) begin
          st_nxt  = S_TIW;
          cnt_nxt = wait_c - 3'd1;
        end else begin
          st_nxt = S_T2;
        end
      end
      S_TIW: begin
        if (cnt_r == 3'd0)
          st_nxt = S_T2;
        else
          cnt_nxt = cnt_r - 3'd1;
      end
      S_T2: begin
        if (!a_wr_r) begin
          if (cur_wide)
            rd_nxt = data_in;
          else if (cur_hi)
            rd_nxt = {data_in[7:0], rd_r[7:0]};
          else
            rd_nxt = {rd_r[15:8], data_in[7:0]};
        end
        if (!a_wr_r && a_bst_r && !a_step_r) begin
          // next byte address goes out with the burst cycle
          a_step_nxt = 1'b1;
          st_nxt = cur_cfg[`SZBCS_WBR_BIT] ? S_TBW : S_T2B;
        end else if (a_wr_r && a_ew_r) begin
          st_nxt = S_T3;
        end else if (hold_c != 2'd0) begin
          st_nxt  = S_HOLD;
          cnt_nxt = {1'b0, hold_c} - 3'd1;
        end
      end
      S_TBW:
        st_nxt = S_T2B;
      S_T2B: begin
        rd_nxt = {data_in[7:0], rd_r[7:0]};
        if (hold_c != 2'd0) begin
          st_nxt  = S_HOLD;
          cnt_nxt = {1'b0, hold_c} - 3'd1;
        end
      end
      S_T3: begin
        if (hold_c != 2'd0) begin
          st_nxt  = S_HOLD;
          cnt_nxt = {1'b0, hold_c} - 3'd1;
        end
      end
      S_HOLD: begin
        if (cnt_r != 3'd0)
          cnt_nxt = cnt_r - 3'd1;
      end
      S_FAST: begin
        if (cur_wide)
          rd_nxt = data_in;
        else if (cur_hi)
          rd_nxt = {data_in[7:0], rd_r[7:0]};
        else
          rd_nxt = {rd_r[15:8], data_in[7:0]};
      end
      S_GAP:
        st_nxt = start_of(a_zone_r, a_fast_r, a_wr_r);
      default: ;
    endcase
    if (term) begin
      done = (st_r != S_IDLE && !sec_pend) ||
             (st_r == S_IDLE && req_valid && req_null);
      if (sec_pend) begin
        a_step_nxt = 1'b1;
        launch     = 1'b1;
      end else if (req_valid && req_ready && !req_null) begin
        launch     = 1'b1;
        a_wr_nxt   = req_write;
        a_ew_nxt   = bus_cfg_r[`SZBCS_EWR_BIT];
        a_zone_nxt = req_zone;
        a_addr_nxt = req_addr;
        a_be_nxt   = req_be;
        a_wd_nxt   = req_wdata;
        a_st_nxt   = req_status;
        a_step_nxt = 1'b0;
        a_fast_nxt = req_cfg[`SZBCS_FRE_BIT] && !req_io;
        // io zone and fast zones never burst; writes never burst
        a_bst_nxt  = !a_fast_nxt && req_cfg[`SZBCS_BRE_BIT] && req_word &&
                     !req_cfg[`SZBCS_BW_BIT] && !req_write && !req_io;
        a_spl_nxt  = req_word && !req_cfg[`SZBCS_BW_BIT] &&
                     !a_bst_nxt && req_zone != `SZBCS_ZONE_INT;
      end else begin
        st_nxt = S_IDLE;
      end
    end
    if (launch) begin
      // every reason for a pause ends in the same single idle clock
      gap = st_r != S_IDLE &&
            ((a_wr_r && a_ew_r && !a_wr_nxt) ||
             (a_wr_r && a_fast_nxt && !a_wr_nxt) ||
             a_zone_nxt == `SZBCS_ZONE_IO ||
             (a_zone_nxt != a_zone_r &&
              (cur_cfg[`SZBCS_IPST_BIT] ||
               (n_cfg[`SZBCS_IPRE_BIT] && a_zone_nxt != `SZBCS_ZONE_IO))));
      st_nxt = gap ? S_GAP : start_of(a_zone_nxt, a_fast_nxt, a_wr_nxt);
    end
  end

  // pin values for the coming clock
  reg  [AW-1:0] addr_nxt;
  reg  [15:0]   dout_nxt;
  reg           doe_nxt;
  reg           sel_on;
  reg           rd_on;
  reg           wr_on;
  reg  [1:0]    zsel_nxt;
  reg           iosel_nxt;
  reg  [1:0]    wrs_nxt;
  wire          n_wide = n_cfg[`SZBCS_BW_BIT];
  wire          n_hi   = !n_wide && (a_step_nxt || a_be_nxt == 2'b10);
  wire          n_ew   = a_wr_nxt && a_ew_nxt;
  wire          n_lw   = a_wr_nxt && !a_ew_nxt;
  wire          n_act  = st_nxt != S_IDLE && st_nxt != S_GAP;

  always @* begin
    addr_nxt = mem_addr;
    if (n_act) begin
      addr_nxt = a_addr_nxt;
      if (a_zone_nxt == `SZBCS_ZONE_IO)
        addr_nxt = {{(AW-8){1'b0}}, a_addr_nxt[7:0]};
      if (n_hi && st_nxt != S_MON)
        addr_nxt[0] = 1'b1;
    end
    case (st_nxt)
      S_T1:          sel_on = !a_wr_nxt || n_lw;
      S_TIW, S_T2:   sel_on = 1'b1;
      S_TBW, S_T2B:  sel_on = 1'b1;
      S_FAST:        sel_on = 1'b1;
      default:       sel_on = 1'b0;
    endcase
    case (st_nxt)
      S_TIW, S_T2:   rd_on = !a_wr_nxt;
      S_TBW, S_T2B:  rd_on = 1'b1;
      S_FAST:        rd_on = 1'b1;
      default:       rd_on = 1'b0;
    endcase
    case (st_nxt)
      S_T1, S_TIW:   wr_on = a_wr_nxt;
      S_T2:          wr_on = n_ew;
      S_T3:          wr_on = n_ew;
      default:       wr_on = 1'b0;
    endcase
    case (st_nxt)
      S_TIW, S_T2:   doe_nxt = a_wr_nxt;
      S_T3, S_HOLD:  doe_nxt = a_wr_nxt;
      default:       doe_nxt = 1'b0;
    endcase
    dout_nxt = data_out;
    if (doe_nxt)
      dout_nxt = n_wide ? a_wd_nxt :
                 {8'h00, n_hi ? a_wd_nxt[15:8] : a_wd_nxt[7:0]};
    zsel_nxt  = 2'b11;
    iosel_nxt = 1'b1;
    if (sel_on) begin
      case (a_zone_nxt)
        `SZBCS_ZONE_0:  zsel_nxt  = 2'b10;
        `SZBCS_ZONE_1:  zsel_nxt  = 2'b01;
        `SZBCS_ZONE_IO: iosel_nxt = 1'b0;
        default:        zsel_nxt  = 2'b11;
      endcase
    end
    // narrow zones qualify every byte with the low strobe
    wrs_nxt = 2'b11;
    if (wr_on)
      wrs_nxt = n_wide ? ~a_be_nxt : 2'b10;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= S_IDLE;
      cnt_r    <= 3'd0;
      a_wr_r   <= 1'b0;
      a_ew_r   <= 1'b1;
      a_zone_r <= 2'h0;
      a_addr_r <= {AW{1'b0}};
      a_be_r   <= 2'b00;
      a_wd_r   <= 16'h0000;
      a_st_r   <= 3'h0;
      a_fast_r <= 1'b0;
      a_bst_r  <= 1'b0;
      a_spl_r  <= 1'b0;
      a_step_r <= 1'b0;
      rd_r     <= 16'h0000;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      a_wr_r   <= a_wr_nxt;
      a_ew_r   <= a_ew_nxt;
      a_zone_r <= a_zone_nxt;
      a_addr_r <= a_addr_nxt;
      a_be_r   <= a_be_nxt;
      a_wd_r   <= a_wd_nxt;
      a_st_r   <= a_st_nxt;
      a_fast_r <= a_fast_nxt;
      a_bst_r  <= a_bst_nxt;
      a_spl_r  <= a_spl_nxt;
      a_step_r <= a_step_nxt;
      rd_r     <= rd_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr            <= {AW{1'b0}};
      data_out            <= 16'h0000;
      data_oe             <= 1'b0;
      zone_select_n       <= 2'b11;
      io_select_n         <= 1'b1;
      read_strobe_n       <= 1'b1;
      write_strobes_n     <= 2'b11;
      core_direction_line <= 1'b0;
      byte_lane_enables   <= 2'b00;
      bus_status_lines    <= 3'h0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 16'h0000;
    end else begin
      mem_addr            <= addr_nxt;
      data_out            <= dout_nxt;
      data_oe             <= doe_nxt;
      zone_select_n       <= zsel_nxt;
      io_select_n         <= iosel_nxt;
      read_strobe_n       <= !rd_on;
      write_strobes_n     <= wrs_nxt;
      // monitoring cycle shows the core side only, no data moves
      core_direction_line <= st_nxt == S_MON && !a_wr_nxt;
      byte_lane_enables   <= st_nxt == S_MON ? a_be_nxt : 2'b00;
      bus_status_lines    <= st_nxt == S_MON ? a_st_nxt : 3'h0;
      rsp_valid           <= done;
      if (done)
        rsp_rdata <= rd_nxt;
    end
  end

  // apb: zero wait, every access answered in its first access cycle
  wire apb_wr = psel && penable && pwrite;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && paddr != `SZBCS_OFF_BUS_CFG &&
                   paddr != `SZBCS_OFF_ZONE0_CFG && paddr != `SZBCS_OFF_ZONE1_CFG &&
                   paddr != `SZBCS_OFF_IO_CFG && paddr != `SZBCS_OFF_STATUS;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_cfg_r   <= `SZBCS_BUS_CFG_RST;
      zone0_cfg_r <= `SZBCS_ZONE_CFG_RST;
      zone1_cfg_r <= `SZBCS_ZONE_CFG_RST;
      io_cfg_r    <= `SZBCS_ZONE_CFG_RST;
    end else if (apb_wr) begin
      case (paddr)
        `SZBCS_OFF_BUS_CFG:
          bus_cfg_r <= (bus_cfg_r & ~`SZBCS_BUS_CFG_WMSK) |
                       (pwdata[7:0] & `SZBCS_BUS_CFG_WMSK);
        `SZBCS_OFF_ZONE0_CFG:
          zone0_cfg_r <= (zone0_cfg_r & ~`SZBCS_ZONE_CFG_WMSK) |
                         (pwdata[15:0] & `SZBCS_ZONE_CFG_WMSK);
        `SZBCS_OFF_ZONE1_CFG:
          zone1_cfg_r <= (zone1_cfg_r & ~`SZBCS_ZONE_CFG_WMSK) |
                         (pwdata[15:0] & `SZBCS_ZONE_CFG_WMSK);
        `SZBCS_OFF_IO_CFG:
          io_cfg_r <= (io_cfg_r & ~`SZBCS_IO_CFG_WMSK) |
                      (pwdata[15:0] & `SZBCS_IO_CFG_WMSK);
        default: ;
      endcase
    end
  end

  always @* begin
    case (paddr)
      `SZBCS_OFF_BUS_CFG:   prdata = {24'h000000, bus_cfg_r};
      `SZBCS_OFF_ZONE0_CFG: prdata = {16'h0000, zone0_cfg_r};
      `SZBCS_OFF_ZONE1_CFG: prdata = {16'h0000, zone1_cfg_r};
      `SZBCS_OFF_IO_CFG:    prdata = {16'h0000, io_cfg_r};
      `SZBCS_OFF_STATUS:    prdata = {26'h0000000, a_step_r, st_r, st_r != S_IDLE};
      default:              prdata = 32'h00000000;
    endcase
  end

endmodule

// >>> hdl/szbcs_consts.vh
// Purpose: constants of the static zone bus cycle sequencer
// Assumes: APB register window of five words
// Notes:   offsets are byte addresses
`ifndef SZBCS_CONSTS_VH
`define SZBCS_CONSTS_VH

`define SZBCS_OFF_BUS_CFG   8'h00
`define SZBCS_OFF_ZONE0_CFG 8'h04
`define SZBCS_OFF_ZONE1_CFG 8'h08
`define SZBCS_OFF_IO_CFG    8'h0c
`define SZBCS_OFF_STATUS    8'h10

`define SZBCS_BUS_CFG_RST   8'h07
`define SZBCS_BUS_CFG_WMSK  8'h03
`define SZBCS_ZONE_CFG_RST  16'h069f
`define SZBCS_ZONE_CFG_WMSK 16'h0eff
`define SZBCS_IO_CFG_WMSK   16'h029f

// bus_cfg fields
`define SZBCS_EWR_BIT 0
`define SZBCS_OBR_BIT 1
// zone_config fields
`define SZBCS_WAIT_LSB 0
`define SZBCS_HOLD_LSB 3
`define SZBCS_BRE_BIT  5
`define SZBCS_WBR_BIT  6
`define SZBCS_BW_BIT   7
`define SZBCS_IPST_BIT 9
`define SZBCS_IPRE_BIT 10
`define SZBCS_FRE_BIT  11

// zone codes on the core request
`define SZBCS_ZONE_0   2'h0
`define SZBCS_ZONE_1   2'h1
`define SZBCS_ZONE_IO  2'h2
`define SZBCS_ZONE_INT 2'h3

`endif
